/* File: sdram_pin_cfg.svh */
// timing counts, field positions and reset values of the sdram pin interface
`ifndef SDRAM_PIN_CFG_SVH
`define SDRAM_PIN_CFG_SVH

`define CLK_PERIOD_NS     40
`define MASK_READ_LAT     2
`define ADDR_W            12
`define COL_W             8
`define DATA_W            16
`define BANK_W            2
`define BANK_N            4
`define PRE_SEL_BIT       10
`define BYTE_W            8
`define CMD_MODE_LOAD     3'h0
`define CMD_REFRESH       3'h1
`define CMD_PRECHARGE     3'h2
`define CMD_ACTIVATE      3'h3
`define CMD_WRITE         3'h4
`define CMD_READ          3'h5
`define CMD_BURST_STOP    3'h6
`define CMD_NOP           3'h7
`define RST_BANK_OPEN     4'h0
`define RST_MASK_PIPE     2'h3
`define RST_OE_N          2'h3

`endif

/* File: sdram_pin_pkg.sv */
// types shared by the sdram pin interface
`include "sdram_pin_cfg.svh"

package sdram_pin_pkg;

   typedef enum logic [2:0] {
      OP_MODE_LOAD  = `CMD_MODE_LOAD,
      OP_REFRESH    = `CMD_REFRESH,
      OP_PRECHARGE  = `CMD_PRECHARGE,
      OP_ACTIVATE   = `CMD_ACTIVATE,
      OP_WRITE      = `CMD_WRITE,
      OP_READ       = `CMD_READ,
      OP_BURST_STOP = `CMD_BURST_STOP,
      OP_NOP        = `CMD_NOP
   } cmd_op_t;

   // gray along run -> power down -> self refresh -> suspend
   typedef enum logic [1:0] {
      ST_RUN          = 2'h0,
      ST_POWER_DOWN   = 2'h1,
      ST_SELF_REFRESH = 2'h3,
      ST_SUSPEND      = 2'h2
   } power_state_t;

   typedef struct packed {
      logic                  valid;
      cmd_op_t               op;
      logic [`BANK_W-1:0]    bank;
      logic [`ADDR_W-1:0]    row;
      logic [`COL_W-1:0]     column_address;
      logic                  auto_precharge;
      logic                  precharge_all;
   } core_cmd_t;

   typedef struct packed {
      logic                  strobe;
      logic [`DATA_W-1:0]    data;
      logic [1:0]            byte_en;
   } core_wr_t;

   typedef struct packed {
      logic                  valid;
      logic [`DATA_W-1:0]    data;
   } core_rd_t;

endpackage : sdram_pin_pkg

/* File: sdram_pin_command_interface.sv */
// pin-level command decode and byte-masked data path of a four-bank sdram
`timescale 1ns/100ps
`include "sdram_pin_cfg.svh"

// one byte lane of the data path: read mask pipe, output gate, write capture
module sdram_byte_lane
   import sdram_pin_pkg::*;
#(
   parameter int LANE_W = `BYTE_W
)
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_b,
   // mask pin of this lane
   input  wire logic              mask,
   // write side
   input  wire logic              wr_beat,
   input  wire logic [LANE_W-1:0] wr_in,
   output logic      [LANE_W-1:0] wr_out,
   output logic                   wr_en,
   // read side
   input  wire logic              rd_valid,
   input  wire logic [LANE_W-1:0] rd_in,
   output logic      [LANE_W-1:0] rd_out,
   output logic                   oe_n
);

   localparam logic [1:0] RST_MASK = `RST_MASK_PIPE;
   localparam logic [1:0] RST_OE   = `RST_OE_N;

   typedef struct packed {
      logic              mask_p1;
      logic              mask_p2;
      logic              oe_n;
      logic [LANE_W-1:0] rd_data;
      logic [LANE_W-1:0] wr_data;
      logic              wr_en;
   } lane_state_t;

   lane_state_t r;
   lane_state_t next_r;

   always_comb begin
      next_r = r;
      // mask pipe advances every clock, also while the clock gate is low
      next_r.mask_p1 = mask;
      next_r.mask_p2 = r.mask_p1;
      // a masked lane floats two clocks after its mask
      next_r.oe_n = !(rd_valid && !r.mask_p2);
      next_r.rd_data = rd_in;
      // write mask belongs to the data word of the same beat
      if (wr_beat) begin
         next_r.wr_data = wr_in;
         next_r.wr_en = !mask;
      end
   end

   // reset leaves the lane masked and floating
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         r <= '0;
         r.mask_p1 <= RST_MASK[0];
         r.mask_p2 <= RST_MASK[0];
         r.oe_n <= RST_OE[0];
      end else begin
         r <= next_r;
      end
   end

   // lane outputs
   assign rd_out = r.rd_data;
   assign oe_n = r.oe_n;
   assign wr_out = r.wr_data;
   assign wr_en = r.wr_en;

endmodule : sdram_byte_lane

module sdram_pin_command_interface
   import sdram_pin_pkg::*;
(
   // clock and reset
   input  wire logic                CLK,
   input  wire logic                RST_B,
   // command pins from the memory controller
   input  wire logic                CKE,
   input  wire logic                CS_N,
   input  wire logic                RAS_N,
   input  wire logic                CAS_N,
   input  wire logic                WE_N,
   input  wire logic [`BANK_W-1:0]  BANK_SELECT,
   input  wire logic [`ADDR_W-1:0]  ADDR,
   // byte masks
   input  wire logic                LOW_BYTE_MASK,
   input  wire logic                HIGH_BYTE_MASK,
   // shared data bus, three-signal form
   input  wire logic [`DATA_W-1:0]  DATA_BUS_IN,
   output logic      [`DATA_W-1:0]  DATA_BUS_OUT,
   output logic      [1:0]          DATA_BUS_OE_N,
   // core side
   input  wire logic                WR_DATA_PHASE,
   input  wire logic                BURST_BUSY,
   input  wire core_rd_t            CORE_RD,
   output core_cmd_t                CORE_CMD,
   output core_wr_t                 CORE_WR,
   // status
   output logic      [`BANK_N-1:0]  BANK_OPEN,
   output power_state_t             POWER_STATE,
   output logic                     EDGE_VALID
);

   typedef struct packed {
      // clock gate synchroniser
      logic                  cke_meta;
      logic                  cke_sync;
      // power and bank state
      power_state_t          state;
      logic                  last_refresh;
      logic [`BANK_N-1:0]    bank_open;
      core_cmd_t             cmd;
      logic                  wr_strobe;
   } state_t;

   state_t  r;
   state_t  next_r;
   cmd_op_t op;
   logic    edge_ok;
   logic    accept;
   logic    pre_all;
   logic    wr_beat;

   // one lane per byte of the data bus
   localparam int LANE_N = `DATA_W / `BYTE_W;

   logic [`DATA_W-1:0] lane_rd_out;
   logic [`DATA_W-1:0] lane_wr_data;
   logic [LANE_N-1:0]  lane_oe_n;
   logic [LANE_N-1:0]  lane_wr_en;
   logic [LANE_N-1:0]  lane_mask;

   // command from the three strobes together
   assign op = cmd_op_t'({RAS_N, CAS_N, WE_N});
   // edge counts only in run state with the gate high
   assign edge_ok = r.cke_sync && (r.state == ST_RUN);
   // chip select gates every new command
   assign accept = edge_ok && !CS_N && (op != OP_NOP);
   assign pre_all = ADDR[`PRE_SEL_BIT];

   // next value of the whole block state
   always_comb begin
      next_r = r;
      // clock gate is asynchronous: two flops before use
      // reset clears both flops, so the first edges after reset enter power-down, or suspend while BURST_BUSY is high
      next_r.cke_meta = CKE;
      next_r.cke_sync = r.cke_meta;
      next_r.cmd = '0;
      next_r.cmd.op = OP_NOP;
      next_r.wr_strobe = 1'b0;

      case (r.state)
         ST_RUN: begin
            if (!r.cke_sync) begin
               // choose the low-power mode from what came before
               if (r.last_refresh) begin
                  next_r.state = ST_SELF_REFRESH;
               end else if (BURST_BUSY) begin
                  next_r.state = ST_SUSPEND;
               end else begin
                  next_r.state = ST_POWER_DOWN;
               end
            end else begin
               // gate high: stay and accept commands
               next_r.state = ST_RUN;
            end
         end
         ST_POWER_DOWN, ST_SELF_REFRESH, ST_SUSPEND: begin
            if (r.cke_sync) begin
               next_r.state = ST_RUN;
            end else begin
               next_r.state = r.state;
            end
         end
         default: begin
            next_r.state = ST_RUN;
         end
      endcase

      // remember a refresh on the last valid edge with chip select low for self-refresh entry
      if (edge_ok && !CS_N) begin
         next_r.last_refresh = (op == OP_REFRESH);
      end

      if (accept) begin
         next_r.cmd.valid = 1'b1;
         next_r.cmd.op = op;
         next_r.cmd.bank = BANK_SELECT;
         next_r.cmd.row = ADDR;
         next_r.cmd.column_address = ADDR[`COL_W-1:0];
         case (op)
            OP_ACTIVATE: begin
               next_r.bank_open[BANK_SELECT] = 1'b1;
            end
            OP_PRECHARGE: begin
               next_r.cmd.precharge_all = pre_all;
               if (pre_all) begin
                  next_r.bank_open = '0;
               end else begin
                  next_r.bank_open[BANK_SELECT] = 1'b0;
               end
            end
            OP_READ, OP_WRITE: begin
               next_r.cmd.auto_precharge = pre_all;
               if (pre_all) begin
                  next_r.bank_open[BANK_SELECT] = 1'b0;
               end
            end
            OP_MODE_LOAD, OP_REFRESH, OP_BURST_STOP: begin
               // no bank changes; the core acts on these alone
               next_r.cmd.auto_precharge = 1'b0;
            end
            default: begin
               next_r.cmd.auto_precharge = 1'b0;
            end
         endcase
      end

      // write beat: the lanes take data and mask of the same word
      if (wr_beat) begin
         next_r.wr_strobe = 1'b1;
      end
   end

   // data beats count only on valid edges
   assign wr_beat = edge_ok && ((accept && op == OP_WRITE) || WR_DATA_PHASE);

   // low mask on bits 7:0, high mask on bits 15:8
   assign lane_mask = {HIGH_BYTE_MASK, LOW_BYTE_MASK};

   for (genvar g = 0; g < LANE_N; g++) begin : g_lane
      sdram_byte_lane #(
         .LANE_W   (`BYTE_W)
      ) sdram_byte_lane_i (
         .clk      (CLK),
         .rst_b    (RST_B),
         .mask     (lane_mask[g]),
         .wr_beat  (wr_beat),
         .wr_in    (DATA_BUS_IN[g*`BYTE_W +: `BYTE_W]),
         .wr_out   (lane_wr_data[g*`BYTE_W +: `BYTE_W]),
         .wr_en    (lane_wr_en[g]),
         .rd_valid (CORE_RD.valid),
         .rd_in    (CORE_RD.data[g*`BYTE_W +: `BYTE_W]),
         .rd_out   (lane_rd_out[g*`BYTE_W +: `BYTE_W]),
         .oe_n     (lane_oe_n[g])
      );
   end

   // one register stage for all block state

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         r <= '0;
         r.state <= ST_RUN;
         r.bank_open <= `RST_BANK_OPEN;
         r.cmd.op <= OP_NOP;
      end else begin
         r <= next_r;
      end
   end

   // data path
   assign DATA_BUS_OUT = lane_rd_out;
   assign DATA_BUS_OE_N = lane_oe_n;

   // core side
   assign CORE_CMD = r.cmd;
   assign CORE_WR = '{
      strobe:  r.wr_strobe,
      data:    lane_wr_data,
      byte_en: lane_wr_en
   };

   // status
   assign BANK_OPEN = r.bank_open;
   assign POWER_STATE = r.state;
   assign EDGE_VALID = edge_ok;

endmodule : sdram_pin_command_interface

/* File: sdram_pin_command_interface_assertions.sv */
// port-level assertions for the sdram pin interface
`timescale 1ns/100ps
module sdram_pin_checker
   import sdram_pin_pkg::*;
(
   // clock and reset
   input wire logic        CLK,
   input wire logic        RST_B,
   // pins
   input wire logic        CS_N,
   input wire logic        RAS_N,
   input wire logic        CAS_N,
   input wire logic        WE_N,
   input wire logic [1:0]  BANK_SELECT,
   input wire logic [11:0] ADDR,
   input wire logic        LOW_BYTE_MASK,
   input wire logic        HIGH_BYTE_MASK,
   input wire logic [15:0] DATA_BUS_IN,
   input wire logic [15:0] DATA_BUS_OUT,
   input wire logic [1:0]  DATA_BUS_OE_N,
   // core and status
   input wire core_rd_t    CORE_RD,
   input wire core_cmd_t   CORE_CMD,
   input wire core_wr_t    CORE_WR,
   input wire logic [3:0]  BANK_OPEN,
   input wire logic        EDGE_VALID
);
   wire logic [2:0] cmd = {RAS_N, CAS_N, WE_N};
   wire logic       acc = EDGE_VALID && !CS_N && cmd != 3'h7;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   cmd_op_a: assert property (acc |=> CORE_CMD.valid && CORE_CMD.op == $past(cmd))
      else $error("command not decoded");
   cmd_bank_a: assert property (acc |=> CORE_CMD.bank == $past(BANK_SELECT))
      else $error("command bank wrong");
   no_start_a: assert property (CS_N || !EDGE_VALID |=> !CORE_CMD.valid && $stable(BANK_OPEN))
      else $error("operation started while ignored");
   pre_all_a: assert property (acc && cmd == 3'h2 && ADDR[10] |=> BANK_OPEN == 4'h0)
      else $error("precharge all left a bank open");
   col_addr_a: assert property (acc && cmd[2:1] == 2'h2 |=> CORE_CMD.column_address == $past(ADDR[7:0])
      && CORE_CMD.auto_precharge == $past(ADDR[10]))
      else $error("column or autoprecharge wrong");
   wr_mask_a: assert property (acc && cmd == 3'h4 |=> CORE_WR.strobe && CORE_WR.data == $past(DATA_BUS_IN)
      && CORE_WR.byte_en == ~$past({HIGH_BYTE_MASK, LOW_BYTE_MASK}))
      else $error("write lanes wrong");
   low_hiz_a: assert property (LOW_BYTE_MASK |=> ##2 DATA_BUS_OE_N[0])
      else $error("masked low lane driven");
   high_drive_a: assert property (!HIGH_BYTE_MASK ##2 CORE_RD.valid |=> !DATA_BUS_OE_N[1]
      && DATA_BUS_OUT == $past(CORE_RD.data))
      else $error("high lane not driven");
endmodule : sdram_pin_checker

/* File: sdram_ctl_model.sv */
// memory controller model on the sdram pins
`timescale 1ns/100ps
module sdram_ctl_model (
   // clock
   input  wire logic        clk,
   // command and mask pins
   output logic             cs_n,
   output logic             ras_n,
   output logic             cas_n,
   output logic             we_n,
   output logic [1:0]       bank_select,
   output logic [11:0]      addr,
   output logic             low_byte_mask,
   output logic             high_byte_mask,
   // data bus
   input  wire logic [15:0] data_bus_out,
   input  wire logic [1:0]  data_bus_oe_n,
   output logic      [15:0] data_bus_in
);
   logic [15:0] wd = 16'h0000;
   logic [15:0] last = 16'h0000;
   logic        wdrv = 1'b0;
   initial {cs_n, ras_n, cas_n, we_n, bank_select, addr, high_byte_mask, low_byte_mask} = 20'hF0000;
   // undriven lane shows the inverse of its last level
   always_comb for (int i = 0; i < 2; i++)
      data_bus_in[i*8+:8] = !data_bus_oe_n[i] ? data_bus_out[i*8+:8] : wdrv ? wd[i*8+:8] : ~last[i*8+:8];
   always_ff @(posedge clk) last <= data_bus_in;
   task automatic cmd(input logic c, input logic [2:0] op, input logic [1:0] b, input logic [11:0] a,
                      input logic [1:0] m, input logic [15:0] d);
      @(posedge clk);
      cs_n <= c;
      {ras_n, cas_n, we_n} <= op;
      bank_select <= b;
      addr <= a;
      {high_byte_mask, low_byte_mask} <= m;
      wd <= d;
      wdrv <= op == 3'h4;
      @(posedge clk);
      cs_n <= 1'b1;
      {ras_n, cas_n, we_n} <= 3'h7;
      wdrv <= 1'b0;
   endtask : cmd
endmodule : sdram_ctl_model

/* File: sdram_pin_command_interface_tb.sv */
// self-checking bench for the sdram pin interface
`timescale 1ns/100ps
module sdram_pin_command_interface_tb;
   import sdram_pin_pkg::*;
   logic         clk = 1'b0;
   logic         rst_b = 1'b0;
   logic         cke = 1'b1;
   logic         wr_data_phase = 1'b0;
   logic         burst_busy = 1'b0;
   logic         cs_n, ras_n, cas_n, we_n, low_byte_mask, high_byte_mask, edge_valid;
   logic [1:0]   bank_select, data_bus_oe_n;
   logic [11:0]  addr;
   logic [15:0]  data_bus_in, data_bus_out;
   logic [3:0]   bank_open;
   core_rd_t     core_rd = '0;
   core_cmd_t    core_cmd;
   core_wr_t     core_wr;
   power_state_t power_state;
   int           n_errors = 0;
   int           n_tests = 0;
   always #20 clk = ~clk;
   sdram_ctl_model sdram_ctl_model_i (.*);
   sdram_pin_command_interface sdram_pin_command_interface_i (.CLK(clk), .RST_B(rst_b), .CKE(cke),
      .CS_N(cs_n), .RAS_N(ras_n), .CAS_N(cas_n), .WE_N(we_n), .BANK_SELECT(bank_select), .ADDR(addr),
      .LOW_BYTE_MASK(low_byte_mask), .HIGH_BYTE_MASK(high_byte_mask), .DATA_BUS_IN(data_bus_in),
      .DATA_BUS_OUT(data_bus_out), .DATA_BUS_OE_N(data_bus_oe_n), .WR_DATA_PHASE(wr_data_phase),
      .BURST_BUSY(burst_busy),
      .CORE_RD(core_rd), .CORE_CMD(core_cmd), .CORE_WR(core_wr), .BANK_OPEN(bank_open),
      .POWER_STATE(power_state), .EDGE_VALID(edge_valid));
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_tests++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask : chk
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, n_errors);
      if (n_errors == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : end_of_test
   initial begin
      repeat (1000) @(posedge clk);
      n_errors++;
      end_of_test();
   end
   initial begin
      repeat (8) @(posedge clk);
      rst_b <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk({edge_valid, data_bus_oe_n}, 3'h7);
      for (int b = 0; b < 4; b++) begin
         sdram_ctl_model_i.cmd(1'b0, 3'h3, b[1:0], 12'h000, 2'h0, 16'h0000);
         #1 chk({core_cmd.valid, core_cmd.bank, bank_open[b]}, {1'b1, b[1:0], 1'b1});
      end
      for (int op = 0; op < 7; op++) begin
         sdram_ctl_model_i.cmd(1'b0, op[2:0], 2'h1, 12'h000, 2'h0, 16'h0000);
         #1 chk({core_cmd.valid, core_cmd.op, bank_open}, {1'b1, op[2:0], (op == 2) ? 4'hD : 4'hF});
      end
      sdram_ctl_model_i.cmd(1'b0, 3'h2, 2'h2, 12'h000, 2'h0, 16'h0000);
      #1 chk(bank_open, 4'hB);
      sdram_ctl_model_i.cmd(1'b0, 3'h5, 2'h0, 12'h4A5, 2'h0, 16'h0000);
      #1 chk({core_cmd.column_address, core_cmd.auto_precharge, bank_open}, 13'h14BA);
      sdram_ctl_model_i.cmd(1'b0, 3'h2, 2'h1, 12'h400, 2'h0, 16'h0000);
      #1 chk(bank_open, 4'h0);
      sdram_ctl_model_i.cmd(1'b1, 3'h3, 2'h2, 12'h000, 2'h0, 16'h0000);
      #1 chk({core_cmd.valid, bank_open}, 5'h00);
      $display("command test done");
      sdram_ctl_model_i.cmd(1'b0, 3'h4, 2'h0, 12'h000, 2'h1, 16'hBEEF);
      #1 chk({core_wr.strobe, core_wr.byte_en}, 3'h6);
      chk(core_wr.data, 16'hBEEF);
      for (int m = 0; m < 4; m++) begin
         sdram_ctl_model_i.cmd(1'b1, 3'h7, 2'h0, 12'h000, m[1:0], 16'h0000);
         core_rd <= {1'b1, 16'h5A00 + 16'(m)};
         repeat (2) @(posedge clk);
         #1 chk({data_bus_oe_n, data_bus_out}, {m[1:0], 16'h5A00 + 16'(m)});
      end
      core_rd <= '0;
      $display("data test done");
      @(posedge clk);
      cke <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk(power_state, ST_POWER_DOWN);
      sdram_ctl_model_i.cmd(1'b0, 3'h3, 2'h3, 12'h000, 2'h0, 16'h0000);
      #1 chk({core_cmd.valid, bank_open}, 5'h00);
      cke <= 1'b1;
      repeat (4) @(posedge clk);
      #1 chk(edge_valid, 1'b1);
      $display("clock gate test done");
      sdram_ctl_model_i.cmd(1'b0, 3'h1, 2'h0, 12'h000, 2'h0, 16'h0000);
      cke <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk(power_state, ST_SELF_REFRESH);
      cke <= 1'b1;
      repeat (4) @(posedge clk);
      sdram_ctl_model_i.cmd(1'b0, 3'h4, 2'h0, 12'h000, 2'h2, 16'h1234);
      wr_data_phase <= 1'b1;
      @(posedge clk);
      wr_data_phase <= 1'b0;
      #1 chk({core_wr.strobe, core_wr.byte_en}, 3'h5);
      burst_busy <= 1'b1;
      cke <= 1'b0;
      repeat (4) @(posedge clk);
      #1 chk(power_state, ST_SUSPEND);
      cke <= 1'b1;
      burst_busy <= 1'b0;
      repeat (4) @(posedge clk);
      $display("low power test done");
      end_of_test();
   end
endmodule : sdram_pin_command_interface_tb
bind sdram_pin_command_interface sdram_pin_checker sdram_pin_checker_i (.*);
